/* pkg/nvm_timing_pkg.sv */
// Constants for the non-volatile memory command sequencer timing block.
// Assumes one bus clock; commands arrive as a code plus a one-cycle launch.
// Function
// - Operation time base divides bus clock
// - No frequency check, never block commands
// - Verify all blocks: 35384 bus cycles
// - Verify flash block: 33337 bus cycles
// - Verify EEPROM block: 2573 bus cycles
// - Verify flash section: 505 bus cycles
// - Key 515, user 427, factory 436
// - EEPROM section 583, read once 481, override 475
// - Program flash 164+3077, once 164+3054
// - Erase all: 100066 op plus 35773
// - Erase flash block: 100060 plus 33596
// - Erase EEPROM block: 100060 plus 2895
// - One EEPROM word: 68 plus 1657
// - Two EEPROM words: 136 plus 2660
// - Three EEPROM words: 204 plus 3663
// - Four EEPROM words: 272 plus 4666
// - Count erase cycles per erased sector
package nvm_timing_pkg;

  localparam int CMD_W    = 5;
  localparam int DIV_W    = 8;
  localparam int OPC_W    = 17;
  localparam int BUSC_W   = 16;
  localparam int SEC_W    = 3;
  localparam int NSEC     = 8;
  localparam int PECNT_W  = 20;

  typedef enum logic [CMD_W-1:0] {
    CMD_VFY_ALL    = 5'h00,
    CMD_VFY_PBLK   = 5'h01,
    CMD_VFY_DBLK   = 5'h02,
    CMD_VFY_PSEC   = 5'h03,
    CMD_READ_ONCE  = 5'h04,
    CMD_PGM_P4     = 5'h05,
    CMD_PGM_ONCE   = 5'h06,
    CMD_ERS_ALL    = 5'h07,
    CMD_ERS_PBLK   = 5'h08,
    CMD_ERS_DBLK   = 5'h09,
    CMD_VFY_KEY    = 5'h0a,
    CMD_MRG_USER   = 5'h0b,
    CMD_MRG_FACT   = 5'h0c,
    CMD_VFY_DSEC   = 5'h0d,
    CMD_PGM_D1     = 5'h0e,
    CMD_PGM_D2     = 5'h0f,
    CMD_PGM_D3     = 5'h10,
    CMD_PGM_D4     = 5'h11,
    CMD_PROT_OVRD  = 5'h12
  } cmd_t;

  localparam logic [BUSC_W-1:0] BUS_VFY_ALL   = 16'd35384;
  localparam logic [BUSC_W-1:0] BUS_VFY_PBLK  = 16'd33337;
  localparam logic [BUSC_W-1:0] BUS_VFY_DBLK  = 16'd2573;
  localparam logic [BUSC_W-1:0] BUS_VFY_PSEC  = 16'd505;
  localparam logic [BUSC_W-1:0] BUS_READ_ONCE = 16'd481;
  localparam logic [BUSC_W-1:0] BUS_PGM_P4    = 16'd3077;
  localparam logic [BUSC_W-1:0] BUS_PGM_ONCE  = 16'd3054;
  localparam logic [BUSC_W-1:0] BUS_ERS_ALL   = 16'd35773;
  localparam logic [BUSC_W-1:0] BUS_ERS_PBLK  = 16'd33596;
  localparam logic [BUSC_W-1:0] BUS_ERS_DBLK  = 16'd2895;
  localparam logic [BUSC_W-1:0] BUS_VFY_KEY   = 16'd515;
  localparam logic [BUSC_W-1:0] BUS_MRG_USER  = 16'd427;
  localparam logic [BUSC_W-1:0] BUS_MRG_FACT  = 16'd436;
  localparam logic [BUSC_W-1:0] BUS_VFY_DSEC  = 16'd583;
  localparam logic [BUSC_W-1:0] BUS_PGM_D1    = 16'd1657;
  localparam logic [BUSC_W-1:0] BUS_PGM_D2    = 16'd2660;
  localparam logic [BUSC_W-1:0] BUS_PGM_D3    = 16'd3663;
  localparam logic [BUSC_W-1:0] BUS_PGM_D4    = 16'd4666;
  localparam logic [BUSC_W-1:0] BUS_PROT_OVRD = 16'd475;

  localparam logic [OPC_W-1:0] OP_NONE    = 17'd0;
  localparam logic [OPC_W-1:0] OP_PGM_P4  = 17'd164;
  localparam logic [OPC_W-1:0] OP_ERS_ALL = 17'd100066;
  localparam logic [OPC_W-1:0] OP_ERS_BLK = 17'd100060;
  localparam logic [OPC_W-1:0] OP_PGM_D1  = 17'd68;
  localparam logic [OPC_W-1:0] OP_PGM_D2  = 17'd136;
  localparam logic [OPC_W-1:0] OP_PGM_D3  = 17'd204;
  localparam logic [OPC_W-1:0] OP_PGM_D4  = 17'd272;

  // Sectors 0..3 belong to program flash, 4..7 to the EEPROM
  localparam logic [NSEC-1:0] MASK_PFLASH = 8'h0f;
  localparam logic [NSEC-1:0] MASK_EEPROM = 8'hf0;
  localparam logic [NSEC-1:0] MASK_ALL    = 8'hff;

endpackage

/* design/nvm_command_timing.sv */
// Command duration sequencer for the flash and EEPROM arrays.
// Assumes commands and divider setting are synchronous to i_clk.
module nvm_command_timing (
  input  wire logic                                  i_clk,
  input  wire logic                                  i_arst_n,
  input  wire logic [nvm_timing_pkg::DIV_W-1:0]      i_nvm_clock_divider,
  input  wire logic                                  i_launch,
  input  wire logic [nvm_timing_pkg::CMD_W-1:0]      i_cmd,
  input  wire logic [nvm_timing_pkg::SEC_W-1:0]      i_sector,
  output logic                                       o_busy,
  output logic                                       o_done,
  output logic                                       o_nvm_operation_clock,
  output logic [nvm_timing_pkg::NSEC*nvm_timing_pkg::PECNT_W-1:0] o_pe_count
);

  typedef enum logic [1:0] {ST_IDLE, ST_OPS, ST_BUS} state_t;

  typedef struct packed {
    state_t                                state;
    logic [nvm_timing_pkg::DIV_W-1:0]      div_cnt;
    logic                                  op_tick;
    logic [nvm_timing_pkg::OPC_W-1:0]      op_left;
    logic [nvm_timing_pkg::BUSC_W-1:0]     bus_left;
    logic                                  done;
    logic [nvm_timing_pkg::NSEC-1:0]       ers_mask;
    logic [nvm_timing_pkg::NSEC*nvm_timing_pkg::PECNT_W-1:0] pe;
  } state_s_t;

  state_s_t q;
  state_s_t d;

  logic [nvm_timing_pkg::OPC_W-1:0]  op_need;
  logic [nvm_timing_pkg::BUSC_W-1:0] bus_need;
  logic [nvm_timing_pkg::NSEC-1:0]   ers_need;
  logic [nvm_timing_pkg::NSEC-1:0]   sec_onehot;

  assign sec_onehot = nvm_timing_pkg::NSEC'(1) << i_sector;

  always_comb begin
    op_need  = nvm_timing_pkg::OP_NONE;
    bus_need = nvm_timing_pkg::BUS_VFY_ALL;
    ers_need = '0;
    case (i_cmd)
      nvm_timing_pkg::CMD_VFY_ALL:   bus_need = nvm_timing_pkg::BUS_VFY_ALL;
      nvm_timing_pkg::CMD_VFY_PBLK:  bus_need = nvm_timing_pkg::BUS_VFY_PBLK;
      nvm_timing_pkg::CMD_VFY_DBLK:  bus_need = nvm_timing_pkg::BUS_VFY_DBLK;
      nvm_timing_pkg::CMD_VFY_PSEC:  bus_need = nvm_timing_pkg::BUS_VFY_PSEC;
      nvm_timing_pkg::CMD_VFY_KEY:   bus_need = nvm_timing_pkg::BUS_VFY_KEY;
      nvm_timing_pkg::CMD_MRG_USER:  bus_need = nvm_timing_pkg::BUS_MRG_USER;
      nvm_timing_pkg::CMD_MRG_FACT:  bus_need = nvm_timing_pkg::BUS_MRG_FACT;
      nvm_timing_pkg::CMD_VFY_DSEC:  bus_need = nvm_timing_pkg::BUS_VFY_DSEC;
      nvm_timing_pkg::CMD_READ_ONCE: bus_need = nvm_timing_pkg::BUS_READ_ONCE;
      nvm_timing_pkg::CMD_PROT_OVRD: bus_need = nvm_timing_pkg::BUS_PROT_OVRD;
      nvm_timing_pkg::CMD_PGM_P4: begin
        op_need  = nvm_timing_pkg::OP_PGM_P4;
        bus_need = nvm_timing_pkg::BUS_PGM_P4;
      end
      nvm_timing_pkg::CMD_PGM_ONCE: begin
        op_need  = nvm_timing_pkg::OP_PGM_P4;
        bus_need = nvm_timing_pkg::BUS_PGM_ONCE;
      end
      nvm_timing_pkg::CMD_ERS_ALL: begin
        op_need  = nvm_timing_pkg::OP_ERS_ALL;
        bus_need = nvm_timing_pkg::BUS_ERS_ALL;
        ers_need = nvm_timing_pkg::MASK_ALL;
      end
      nvm_timing_pkg::CMD_ERS_PBLK: begin
        op_need  = nvm_timing_pkg::OP_ERS_BLK;
        bus_need = nvm_timing_pkg::BUS_ERS_PBLK;
        ers_need = nvm_timing_pkg::MASK_PFLASH;
      end
      nvm_timing_pkg::CMD_ERS_DBLK: begin
        op_need  = nvm_timing_pkg::OP_ERS_BLK;
        bus_need = nvm_timing_pkg::BUS_ERS_DBLK;
        ers_need = nvm_timing_pkg::MASK_EEPROM;
      end
      nvm_timing_pkg::CMD_PGM_D1: begin
        op_need  = nvm_timing_pkg::OP_PGM_D1;
        bus_need = nvm_timing_pkg::BUS_PGM_D1;
      end
      nvm_timing_pkg::CMD_PGM_D2: begin
        op_need  = nvm_timing_pkg::OP_PGM_D2;
        bus_need = nvm_timing_pkg::BUS_PGM_D2;
      end
      nvm_timing_pkg::CMD_PGM_D3: begin
        op_need  = nvm_timing_pkg::OP_PGM_D3;
        bus_need = nvm_timing_pkg::BUS_PGM_D3;
      end
      nvm_timing_pkg::CMD_PGM_D4: begin
        op_need  = nvm_timing_pkg::OP_PGM_D4;
        bus_need = nvm_timing_pkg::BUS_PGM_D4;
      end
      // Unknown codes still time as a full verify, never hang
      default: bus_need = nvm_timing_pkg::BUS_VFY_ALL;
    endcase
  end

  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (q.div_cnt >= i_nvm_clock_divider) begin
      d.div_cnt = '0;
      d.op_tick = 1'b1;
    end else begin
      d.div_cnt = q.div_cnt + 1'b1;
      d.op_tick = 1'b0;
    end
    case (q.state)
      ST_IDLE: begin
        if (i_launch) begin
          d.op_left  = op_need;
          d.bus_left = bus_need;
          d.ers_mask = ers_need;
          if (i_cmd == nvm_timing_pkg::CMD_VFY_PSEC) begin
            d.ers_mask = '0;
          end
          d.state = (op_need != '0) ? ST_OPS : ST_BUS;
        end
      end
      ST_OPS: begin
        if (q.op_tick) begin
          d.op_left = q.op_left - 1'b1;
          if (q.op_left == nvm_timing_pkg::OPC_W'(1)) begin
            d.state = ST_BUS;
          end
        end
      end
      ST_BUS: begin
        d.bus_left = q.bus_left - 1'b1;
        if (q.bus_left == nvm_timing_pkg::BUSC_W'(1)) begin
          d.state = ST_IDLE;
          d.done  = 1'b1;
          d.ers_mask = '0;
        end
      end
      default: d.state = ST_IDLE;
    endcase
  end

  logic [nvm_timing_pkg::PECNT_W-1:0] d_pe_slice [nvm_timing_pkg::NSEC];
  logic [nvm_timing_pkg::NSEC*nvm_timing_pkg::PECNT_W-1:0] pe_next;

  genvar g;
  generate
    for (g = 0; g < nvm_timing_pkg::NSEC; g++) begin : g_pe
      logic bump;
      assign bump = q.ers_mask[g] && q.state == ST_BUS &&
                    q.bus_left == nvm_timing_pkg::BUSC_W'(1);
      assign d_pe_slice[g] = q.pe[g*nvm_timing_pkg::PECNT_W +:
                                  nvm_timing_pkg::PECNT_W] +
                             nvm_timing_pkg::PECNT_W'(bump);
    end
  endgenerate

  always_comb begin
    for (int i = 0; i < nvm_timing_pkg::NSEC; i++) begin
      pe_next[i*nvm_timing_pkg::PECNT_W +: nvm_timing_pkg::PECNT_W] =
        d_pe_slice[i];
    end
  end

  state_s_t d_full;
  always_comb begin
    d_full    = d;
    d_full.pe = pe_next;
  end

  // Counts are volatile; a real part would keep them in the array itself
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= d_full;
    end
  end

  assign o_busy                = q.state != ST_IDLE;
  assign o_done                = q.done;
  assign o_nvm_operation_clock = q.op_tick;
  assign o_pe_count            = q.pe;

  logic unused_sec;
  assign unused_sec = ^sec_onehot;

endmodule

/* test/nvm_command_timing_props.sv */
// Checker of busy, done and erase counter timing at the sequencer ports.
// Assumes one clock domain and the port list of the top module.
module nvm_command_timing_props (
  input wire logic         i_clk,
  input wire logic         i_arst_n,
  input wire logic [7:0]   i_nvm_clock_divider,
  input wire logic         i_launch,
  input wire logic [4:0]   i_cmd,
  input wire logic [2:0]   i_sector,
  input wire logic         o_busy,
  input wire logic         o_done,
  input wire logic         o_nvm_operation_clock,
  input wire logic [159:0] o_pe_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic [15:0] cnt_q;
  logic [4:0]  cmd_q;
  // Busy cycles since the accepted launch; refused launches leave it alone
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= 16'h0000;
      cmd_q <= 5'h00;
    end else if (i_launch && !o_busy) begin
      cnt_q <= 16'h0000;
      cmd_q <= i_cmd;
    end else if (o_busy) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  property p_take; i_launch && !o_busy |=> o_busy && !o_done; endproperty
  a_take: assert property (p_take) else $error("launch not taken");
  property p_fall; $fell(o_busy) |-> o_done; endproperty
  a_fall: assert property (p_fall) else $error("busy fell, no done");
  property p_one; o_done |=> !o_done; endproperty
  a_one: assert property (p_one) else $error("done too long");
  property p_src; o_done |-> !o_busy && $past(o_busy); endproperty
  a_src: assert property (p_src) else $error("done without busy");
  property p_idle; !o_busy && !i_launch |=> !o_busy; endproperty
  a_idle: assert property (p_idle) else $error("busy from nothing");
  property p_psec; o_done && cmd_q == 5'h03 |-> cnt_q == 16'd505; endproperty
  a_psec: assert property (p_psec) else $error("section verify length");
  property p_key; o_done && cmd_q == 5'h0a |-> cnt_q == 16'd515; endproperty
  a_key: assert property (p_key) else $error("key verify length");
  property p_dblk; o_done && cmd_q == 5'h02 |-> cnt_q == 16'd2573; endproperty
  a_dblk: assert property (p_dblk) else $error("block verify length");
  property p_pe; $changed(o_pe_count) |-> o_done || $past(o_done); endproperty
  a_pe: assert property (p_pe) else $error("count moved off done");
  property p_tick;
    o_nvm_operation_clock && i_nvm_clock_divider != 8'h00
      |=> !o_nvm_operation_clock;
  endproperty
  a_tick: assert property (p_tick) else $error("tick too close");
  c_take: cover property (i_launch && !o_busy);
  c_refuse: cover property (i_launch && o_busy);
  c_done: cover property (o_done);
endmodule

/* test/nvm_command_timing_tb.sv */
// Self-checking bench for the command duration sequencer.
// Assumes 100 MHz; full erases exceed the run budget and are launched, then reset after 100 cycles.
module nvm_command_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic         i_clk = 1'b0;
  logic         i_arst_n = 1'b0;
  logic [7:0]   i_nvm_clock_divider = 8'h00;
  logic         i_launch = 1'b0;
  logic [4:0]   i_cmd = 5'h00;
  logic [2:0]   i_sector = 3'h0;
  logic         o_busy;
  logic         o_done;
  logic         o_nvm_operation_clock;
  logic [159:0] o_pe_count;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;
  logic [31:0] ticks;
  logic [4:0]  ers [3] = '{5'h07, 5'h08, 5'h09};
  // Code and busy length with one operation tick per bus cycle
  logic [4:0] codes [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
    5'h06, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12};
  int lens [16] = '{35384, 33337, 2573, 505, 481, 3241, 3218, 515, 427,
    436, 583, 1725, 2796, 3867, 4938, 475};
  nvm_command_timing u_dut (.i_clk, .i_arst_n, .i_nvm_clock_divider,
    .i_launch, .i_cmd, .i_sector, .o_busy, .o_done,
    .o_nvm_operation_clock, .o_pe_count);
  // fixed bench clock; durations are counted in cycles
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 100000) begin
      err_total++;
      close_out();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Ends in the done cycle, so the next call launches back to back
  task automatic run(input logic [4:0] c);
    i_cmd = c;
    i_launch = 1'b1;
    @(negedge i_clk);
    i_launch = 1'b0;
    n = 0;
    while (o_busy === 1'b1 && n < 200000) begin
      n++;
      @(negedge i_clk);
    end
  endtask
  initial begin
    repeat (12) @(negedge i_clk);
    check({o_busy, o_done, |o_pe_count}, 0);
    i_arst_n = 1'b1;
    for (int r = 0; r < 16; r++) begin
      i_sector = r[2:0];
      run(codes[r]);
      check(n, lens[r]);
      check(o_done, 1);
    end
    check(|o_pe_count, 0);
    // Op clock 25 MHz is out of range yet must not block the command
    // software keeps range
    i_nvm_clock_divider = 8'h03;
    run(5'h0e);
    check(n >= 1925 && n <= 1933, 1);
    ticks = 32'h00000000;
    repeat (40) begin
      @(negedge i_clk);
      ticks = ticks + 32'(o_nvm_operation_clock);
    end
    check(ticks, 32'h0000000a);
    i_nvm_clock_divider = 8'h00;
    // Launch held through busy is refused until done
    i_cmd = 5'h03;
    i_launch = 1'b1;
    @(negedge i_clk);
    i_cmd = 5'h0a;
    n = 0;
    while (o_busy === 1'b1 && n < 9999) begin
      n++;
      @(negedge i_clk);
    end
    check(n, 505);
    @(negedge i_clk);
    i_launch = 1'b0;
    repeat (50) @(negedge i_clk);
    i_arst_n = 1'b0;
    @(negedge i_clk);
    check({o_busy, o_done}, 0);
    i_arst_n = 1'b1;
    // Erases outlast the budget: check they hold busy, then abort
    for (int e = 0; e < 3; e++) begin
      i_cmd = ers[e];
      i_launch = 1'b1;
      @(negedge i_clk);
      i_launch = 1'b0;
      repeat (100) @(negedge i_clk);
      check({o_busy, o_done, |o_pe_count}, 3'h4);
      i_arst_n = 1'b0;
      @(negedge i_clk);
      i_arst_n = 1'b1;
    end
    run(5'h04);
    check(n, 481);
    close_out();
  end
endmodule
bind nvm_command_timing nvm_command_timing_props u_props (.i_clk,
  .i_arst_n, .i_nvm_clock_divider, .i_launch, .i_cmd, .i_sector, .o_busy,
  .o_done, .o_nvm_operation_clock, .o_pe_count);
